/* File: include/scci_defs.svh */
// Register offsets, field positions and reset values of the command block
`ifndef SCCI_DEFS_SVH
`define SCCI_DEFS_SVH
`define SCCI_ADDR_W 4
`define SCCI_OFF_CMD 4'h0
`define SCCI_OFF_CFG 4'h1
`define SCCI_OFF_STAT 4'h2
`define SCCI_OFF_IRQ 4'h3
`define SCCI_OFF_MASK 4'h4
`define SCCI_OFF_POS 4'h5
`define SCCI_OFF_ALARM 4'h6
`define SCCI_CMD_EN 0
`define SCCI_CMD_DONE 1
`define SCCI_CMD_IMM 2
`define SCCI_CFG_FALL 0
`define SCCI_CFG_SAW 1
`define SCCI_CFG_HWMAP 2
`define SCCI_EV_DONE 0
`define SCCI_EV_IMM 1
`define SCCI_EV_ALARM 2
`define SCCI_EV_HOME 3
`define SCCI_EV_W 4
`define SCCI_POS_W 16
`define SCCI_ALARM_RST 16'h1000
`define SCCI_DEC_STEP 16'h0001
`define SCCI_ZERO_POS 16'h0000
`define SCCI_SAW_CUT_CYC 8'h10
`define SCCI_UNMAPPED 32'hDEADBEEF
`endif

/* File: include/scci_pkg.sv */
// Types shared by the shear cut command block
package scci_pkg;
    typedef enum logic [1:0] {
        SCCI_IDLE = 2'b00,
        SCCI_SYNC = 2'b01,
        SCCI_DECEL = 2'b10,
        SCCI_RETURN = 2'b11
    } scci_state_e;
    typedef struct packed {
        logic en;
        logic done;
        logic imm;
    } scci_cmd_s;
endpackage

/* File: src/scci_top.sv */
// Shear cut command inputs: enable, cut completed and immediate cut
//
// Contract
// - Enable off disables the whole controller and all its functions.
// - Enable off forces every analog output to zero.
// - Enable off holds all internal counters in reset.
// - Enable on lets the control functions run.
// - Enable unmapped to hardware is set automatically after power on.
// - A setting picks rising or falling edge for cut completed.
// - Selected cut-completed edge starts deceleration, then reversal.
// - Reversal brings the carriage back to its rear home.
// - Without cut completed, carriage keeps following the material.
// - At alarm position raise alarm output, never stop the carriage.
// - Saw mode 1 generates cut completed internally.
// - Immediate-cut rising edge starts a cut cycle regardless of state.
// - Each command is hardware OR serial OR fieldbus source.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "scci_defs.svh"
module scci_top #(
    parameter int POS_W = `SCCI_POS_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [`SCCI_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire scci_pkg::scci_cmd_s hw_cmd,
    input wire scci_pkg::scci_cmd_s bus_cmd,
    input wire logic saw_axis_used,
    input wire logic [POS_W-1:0] master_speed,
    output logic [POS_W-1:0] analog_out,
    output logic [POS_W-1:0] carriage_pos,
    output logic cut_start,
    output logic alarm_out,
    output logic carriage_home,
    output logic ctrl_enabled,
    output logic irq
);
    import scci_pkg::*;

    scci_cmd_s ser_cmd_r;
    logic [2:0] cfg_r;
    logic [`SCCI_EV_W-1:0] stat_r;
    logic [`SCCI_EV_W-1:0] mask_r;
    logic [POS_W-1:0] alarm_pos_r;
    logic [POS_W-1:0] pos_r;
    logic [POS_W-1:0] speed_r;
    logic [POS_W-1:0] analog_r;
    scci_state_e state_r;
    scci_cmd_s cmd;
    scci_cmd_s prev_r;
    logic en_auto_r;
    logic init_done_r;
    logic done_edge;
    logic imm_edge;
    logic saw_done;
    logic cut_start_r;
    logic alarm_r;
    logic [7:0] saw_cnt_r;
    logic [`SCCI_EV_W-1:0] ev;
    logic rd_ack_r;
    logic wr_sel;

    // Three sources are ORed into one command
    always_comb begin
        cmd = hw_cmd | ser_cmd_r | bus_cmd;
        // Unmapped enable is taken from the power-on latch instead
        if (!cfg_r[`SCCI_CFG_HWMAP]) begin
            cmd.en = en_auto_r | ser_cmd_r.en | bus_cmd.en;
        end
    end

    assign ctrl_enabled = cmd.en;

    // Previous-sample compare yields one event per edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '0;
        end else begin
            prev_r <= cmd;
        end
    end

    always_comb begin
        if (cfg_r[`SCCI_CFG_FALL]) begin
            done_edge = prev_r.done & ~cmd.done;
        end else begin
            done_edge = ~prev_r.done & cmd.done;
        end
        imm_edge = ~prev_r.imm & cmd.imm;
    end

    // Enable latch set once after reset release when not wired to a pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_auto_r <= 1'b0;
            init_done_r <= 1'b0;
        end else if (!init_done_r) begin
            init_done_r <= 1'b1;
            en_auto_r <= 1'b1;
        end
    end

    // Saw mode 1: a fixed cut time stands in for the external signal
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            saw_cnt_r <= '0;
        end else if (!cmd.en || !(cfg_r[`SCCI_CFG_SAW] && saw_axis_used)) begin
            saw_cnt_r <= '0;
        end else if (cut_start_r) begin
            saw_cnt_r <= `SCCI_SAW_CUT_CYC;
        end else if (saw_cnt_r != 8'h00) begin
            saw_cnt_r <= saw_cnt_r - 8'h01;
        end
    end

    assign saw_done = (saw_cnt_r == 8'h01);

    // Carriage sequence
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SCCI_IDLE;
        end else if (!cmd.en) begin
            state_r <= SCCI_IDLE;
        end else if (imm_edge) begin
            state_r <= SCCI_SYNC;
        end else begin
            unique case (state_r)
                SCCI_IDLE: begin
                    state_r <= SCCI_IDLE;
                end
                SCCI_SYNC: begin
                    // Machinery reports a finished cut; saw mode makes it here
                    if (done_edge || saw_done) begin
                        state_r <= SCCI_DECEL;
                    end
                end
                SCCI_DECEL: begin
                    if (speed_r == `SCCI_ZERO_POS) begin
                        state_r <= SCCI_RETURN;
                    end
                end
                SCCI_RETURN: begin
                    if (pos_r == `SCCI_ZERO_POS) begin
                        state_r <= SCCI_IDLE;
                    end
                end
            endcase
        end
    end

    // Carriage speed follows the material while synchronised
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            speed_r <= '0;
        end else if (!cmd.en) begin
            speed_r <= '0;
        end else if (state_r == SCCI_SYNC) begin
            speed_r <= master_speed;
        end else if (state_r == SCCI_DECEL && speed_r != `SCCI_ZERO_POS) begin
            speed_r <= speed_r - `SCCI_DEC_STEP;
        end else if (state_r == SCCI_RETURN) begin
            speed_r <= master_speed;
        end else begin
            speed_r <= '0;
        end
    end

    // Position counter; alarm never halts motion, by design of the machine
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pos_r <= '0;
        end else if (!cmd.en) begin
            pos_r <= '0;
        end else if (state_r == SCCI_RETURN) begin
            if (pos_r > speed_r) begin
                pos_r <= pos_r - speed_r;
            end else begin
                pos_r <= `SCCI_ZERO_POS;
            end
        end else if (state_r == SCCI_SYNC || state_r == SCCI_DECEL) begin
            // Idle holds: the speed left over from the return must not
            // push the carriage off its home position again
            pos_r <= pos_r + speed_r;
        end
    end

    // Analog drive command is zero from the first clock after enable drops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            analog_r <= '0;
        end else if (!cmd.en) begin
            analog_r <= '0;
        end else begin
            analog_r <= speed_r;
        end
    end

    // One-cycle cut strobe per immediate-cut edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cut_start_r <= 1'b0;
        end else begin
            cut_start_r <= cmd.en & imm_edge;
        end
    end

    // Alarm only reports; the carriage keeps moving past it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= cmd.en & (pos_r >= alarm_pos_r);
        end
    end

    assign analog_out = analog_r;
    assign carriage_pos = pos_r;
    assign cut_start = cut_start_r;
    assign alarm_out = alarm_r;
    assign carriage_home = (pos_r == `SCCI_ZERO_POS);

    always_comb begin
        ev = '0;
        ev[`SCCI_EV_DONE] = cmd.en & (done_edge | saw_done);
        ev[`SCCI_EV_IMM] = cut_start_r;
        ev[`SCCI_EV_ALARM] = cmd.en & (pos_r >= alarm_pos_r) & ~alarm_r;
        ev[`SCCI_EV_HOME] = (state_r == SCCI_RETURN) &
            (pos_r == `SCCI_ZERO_POS);
    end

    // Avalon slave: writes in one cycle, reads wait one cycle for data
    assign wr_sel = avs_write;
    assign avs_waitrequest = avs_read & ~rd_ack_r;

    // Serial-link command flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ser_cmd_r <= '0;
        end else if (wr_sel && avs_address == `SCCI_OFF_CMD) begin
            ser_cmd_r <= avs_writedata[2:0];
        end
    end

    // Edge select, saw mode and enable mapping
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= '0;
        end else if (wr_sel && avs_address == `SCCI_OFF_CFG) begin
            cfg_r <= avs_writedata[2:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= '0;
        end else if (wr_sel && avs_address == `SCCI_OFF_MASK) begin
            mask_r <= avs_writedata[`SCCI_EV_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_pos_r <= `SCCI_ALARM_RST;
        end else if (wr_sel && avs_address == `SCCI_OFF_ALARM) begin
            alarm_pos_r <= avs_writedata[POS_W-1:0];
        end
    end

    // Set wins over write-one-to-clear, so no event is lost to a clear
    genvar gi;
    generate
        for (gi = 0; gi < `SCCI_EV_W; gi++) begin : g_stat
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    stat_r[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    stat_r[gi] <= 1'b1;
                end else if (wr_sel && avs_address == `SCCI_OFF_IRQ &&
                    avs_writedata[gi]) begin
                    stat_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq = |(stat_r & mask_r);

    // Read acknowledge toggles so each read waits exactly one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack_r <= 1'b0;
        end else begin
            rd_ack_r <= avs_read & ~rd_ack_r;
        end
    end

    // Read data is loaded in the wait cycle and stands until the next read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else begin
            if (avs_read && !rd_ack_r) begin
                unique case (avs_address)
                    `SCCI_OFF_CMD: avs_readdata <= {29'h0, ser_cmd_r};
                    `SCCI_OFF_CFG: avs_readdata <= {29'h0, cfg_r};
                    `SCCI_OFF_STAT: avs_readdata <= {27'h0, state_r,
                        cmd};
                    `SCCI_OFF_IRQ: avs_readdata <= {28'h0, stat_r};
                    `SCCI_OFF_MASK: avs_readdata <= {28'h0, mask_r};
                    `SCCI_OFF_POS: avs_readdata <= {16'h0, pos_r};
                    `SCCI_OFF_ALARM: avs_readdata <= {16'h0, alarm_pos_r};
                    default: avs_readdata <= `SCCI_UNMAPPED;
                endcase
            end
        end
    end
endmodule

/* File: bench/scci_top_asserts.sv */
// Checker for the shear cut command block ports
`timescale 1ns/10ps
module scci_top_asserts #(
    parameter int POS_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire scci_pkg::scci_cmd_s hw_cmd,
    input wire scci_pkg::scci_cmd_s bus_cmd,
    input wire logic [POS_W-1:0] master_speed,
    input wire logic [POS_W-1:0] analog_out,
    input wire logic [POS_W-1:0] carriage_pos,
    input wire logic cut_start,
    input wire logic alarm_out,
    input wire logic carriage_home,
    input wire logic ctrl_enabled
);
    import scci_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Registered outputs need one cycle to settle after enable drops
    sequence s_off_held;
        !ctrl_enabled ##1 !ctrl_enabled;
    endsequence
    sequence s_imm_rise;
        $rose(hw_cmd.imm | bus_cmd.imm) && ctrl_enabled;
    endsequence
    a_off_quiet: assert property (s_off_held |-> !cut_start && !alarm_out)
        else $error("activity while disabled");
    a_off_analog: assert property (s_off_held |-> analog_out == '0)
        else $error("analog output not zero while disabled");
    a_off_counter: assert property (s_off_held |-> carriage_pos == '0)
        else $error("position counter not held while disabled");
    a_auto_en: assert property ($rose(rst_n) |-> ##[1:2] ctrl_enabled)
        else $error("enable not set after reset");
    a_imm_starts: assert property (s_imm_rise |-> ##[1:3] cut_start)
        else $error("immediate cut edge gave no cut start");
    a_cut_single: assert property (cut_start |=> !cut_start)
        else $error("cut start longer than one cycle");
    a_follow_mat: assert property (cut_start && master_speed != '0
        |-> ##2 carriage_pos > $past(carriage_pos))
        else $error("carriage not following material");
    a_home_flag: assert property (carriage_home == (carriage_pos == '0))
        else $error("home flag disagrees with position");
    a_alarm_moves: assert property ($rose(alarm_out)
        && master_speed != '0 |=> carriage_pos != $past(carriage_pos))
        else $error("carriage stopped at alarm");
endmodule
bind scci_top scci_top_asserts #(.POS_W(POS_W)) scci_top_asserts_i (
    .mclk, .rst_n, .hw_cmd, .bus_cmd, .master_speed, .analog_out,
    .carriage_pos, .cut_start, .alarm_out, .carriage_home, .ctrl_enabled);

/* File: bench/scci_machine.sv */
// Machine model: reports cut completed a while after each cut start seen while armed
`timescale 1ns/10ps
module scci_machine #(
    parameter int DELAY = 20,
    parameter int WIDTH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic armed,
    input wire logic cut_start,
    output logic cut_done
);
    int cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
        end else if (cut_start && armed) begin
            cnt <= DELAY + WIDTH;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // Pulse only once the stroke has fully finished
    assign cut_done = (cnt > 0) && (cnt <= WIDTH);
endmodule

/* File: bench/tb.sv */
// Testbench for the shear cut command block
`timescale 1ns/10ps
`include "scci_defs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t mismatch", $time); end end
module tb;
    import scci_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic avs_waitrequest;
    logic hw_en = 1'b0;
    logic hw_imm = 1'b0;
    logic armed = 1'b1;
    logic saw = 1'b0;
    logic alarm_seen = 1'b0;
    logic cut_done, cut_start, alarm_out, carriage_home, ctrl_enabled, irq;
    logic [15:0] speed = 16'h0002;
    logic [15:0] analog_out, carriage_pos;
    scci_cmd_s bus_cmd = 3'h0;
    scci_cmd_s hw_cmd;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    assign hw_cmd = '{en: hw_en, done: cut_done, imm: hw_imm};
    initial begin
        forever #4 mclk = ~mclk;
    end
    scci_top scci_top_i (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .hw_cmd, .bus_cmd,
        .saw_axis_used(saw), .master_speed(speed), .analog_out,
        .carriage_pos, .cut_start, .alarm_out, .carriage_home,
        .ctrl_enabled, .irq);
    scci_machine scci_machine_i (.mclk, .rst_n, .armed, .cut_start,
        .cut_done);
    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (alarm_out === 1'b1) alarm_seen <= 1'b1;
        if (cyc == 20000) begin
            errors++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        `CHK(s, v)
    endtask
    // Source 0 hardware, 1 fieldbus, 2 serial flag
    task automatic do_cut(input int src);
        @(posedge mclk);
        if (src == 0) hw_imm <= 1'b1;
        if (src == 1) bus_cmd.imm <= 1'b1;
        if (src == 2) bus(1'b1, `SCCI_OFF_CMD, 32'h1);
        wait_for(cut_start, 1'b1);
        @(posedge mclk);
        hw_imm <= 1'b0;
        bus_cmd.imm <= 1'b0;
        if (src == 2) bus(1'b1, `SCCI_OFF_CMD, 32'h0);
        wait_for(carriage_home, 1'b0);
        bus(1'b0, `SCCI_OFF_STAT, 32'h0);
        `CHK(q[4:3], 2'h1)
        wait_for(carriage_home, 1'b1);
        bus(1'b0, `SCCI_OFF_STAT, 32'h0);
        `CHK(q[4:3], 2'h0)
        $display("cut test with source %0d done", src);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        `CHK(carriage_home, 1'b1)
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK(ctrl_enabled, 1'b1)
        bus(1'b0, `SCCI_OFF_ALARM, 32'h0);
        `CHK(q, 32'h1000)
        bus(1'b0, 4'h7, 32'h0);
        `CHK(q, `SCCI_UNMAPPED)
        bus(1'b1, `SCCI_OFF_ALARM, 32'h8);
        do_cut(0);
        `CHK(alarm_seen, 1'b1)
        `CHK(irq, 1'b0)
        bus(1'b1, `SCCI_OFF_MASK, 32'hF);
        bus(1'b0, `SCCI_OFF_IRQ, 32'h0);
        `CHK(q[3:0], 4'hF)
        `CHK(irq, 1'b1)
        bus(1'b1, `SCCI_OFF_IRQ, 32'hF);
        bus(1'b0, `SCCI_OFF_IRQ, 32'h0);
        `CHK(q[3:0], 4'h0)
        `CHK(irq, 1'b0)
        bus(1'b1, `SCCI_OFF_CFG, 32'h1);
        do_cut(1);
        bus(1'b1, `SCCI_OFF_CFG, 32'h0);
        do_cut(2);
        armed <= 1'b0;
        saw <= 1'b1;
        bus(1'b1, `SCCI_OFF_CFG, 32'h2);
        do_cut(0);
        saw <= 1'b0;
        bus(1'b1, `SCCI_OFF_CFG, 32'h0);
        hw_imm <= 1'b1;
        wait_for(carriage_home, 1'b0);
        @(posedge mclk);
        hw_imm <= 1'b0;
        bus(1'b1, `SCCI_OFF_CFG, 32'h4);
        wait_for(carriage_home, 1'b1);
        `CHK(ctrl_enabled, 1'b0)
        `CHK(analog_out, 16'h0000)
        @(posedge mclk);
        armed <= 1'b1;
        hw_en <= 1'b1;
        wait_for(ctrl_enabled, 1'b1);
        do_cut(0);
        $display("enable test done");
        report_and_stop();
    end
endmodule
